// ---- rtl/dph_handshake.sv ----
// Peripheral handshake for two DMA channels: request in, sampled and
// transfer acknowledges out, shared terminate/sampled-ack pin.
// Assumes DMA core drives ctrl on mclk; pins are asynchronous to mclk.
// Notes on behaviour
// - Each of the two request inputs accepts peripheral DMA service requests.
// - Sampled acknowledge pulses when a pending request has been sampled.
// - Transfer acknowledge pulses for each bus transaction done for the peripheral, except when a terminate input closes the channel in that cycle.
// - Driving terminate out makes the serving channel inactive until the core drops enable or pin_sel.
// - Terminate asserted as input closes the channel like normal completion.
// - Mode picks sampled-ack or terminate on the shared pin, and direction.
// - Handshake function is active only when the pin is selected for it.
`timescale 1ns/1ps
`default_nettype none
`include "dph_cfg.svh"

module dph_handshake (
  input  wire logic                                    mclk,
  input  wire logic                                    rst_n,
  input  wire dph_pkg::dph_ctrl_type [`DPH_NUM_SETS-1:0] ctrl,
  output var  dph_pkg::dph_stat_type [`DPH_NUM_SETS-1:0] stat,
  input  wire logic [`DPH_NUM_SETS-1:0]               ext_service_request,
  output logic [`DPH_NUM_SETS-1:0]                    transfer_ack,
  output logic [`DPH_NUM_SETS-1:0]                    request_sampled_ack,
  input  wire logic [`DPH_NUM_SETS-1:0]               channel_terminate_in,
  output logic [`DPH_NUM_SETS-1:0]                    channel_terminate_out,
  output logic [`DPH_NUM_SETS-1:0]                    channel_terminate_oe
);

  localparam int N = `DPH_NUM_SETS;

  // Two-stage synchronisers; first stage feeds only the second
  logic [N-1:0] req_s1_q;
  logic [N-1:0] req_s2_q;
  logic [N-1:0] trm_s1_q;
  logic [N-1:0] trm_s2_q;
  logic [N-1:0] trm_prev_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_q   <= '0;
      req_s2_q   <= '0;
      trm_s1_q   <= '0;
      trm_s2_q   <= '0;
      trm_prev_q <= '0;
    end else begin
      req_s1_q   <= ext_service_request;
      req_s2_q   <= req_s1_q;
      trm_s1_q   <= channel_terminate_in;
      trm_s2_q   <= trm_s1_q;
      trm_prev_q <= trm_s2_q;
    end
  end

  dph_pkg::dph_state_type [N-1:0] st_q;
  dph_pkg::dph_state_type [N-1:0] st_d;
  logic [N-1:0] rack_q;
  logic [N-1:0] rack_d;
  logic [N-1:0] tack_q;
  logic [N-1:0] tack_d;
  logic [N-1:0] tout_q;
  logic [N-1:0] tout_d;
  logic [N-1:0] toe_q;
  logic [N-1:0] toe_d;
  logic [N-1:0] peer_q;
  logic [N-1:0] peer_d;
  logic [N-1:0] cpulse_q;
  logic [N-1:0] cpulse_d;

  // Terminate input only counts on its rising edge, so a held level
  // cannot close a channel reopened afterwards
  function automatic logic term_rise(input logic cur, input logic prev);
    term_rise = cur & ~prev;
  endfunction : term_rise

  always_comb begin
    for (int i = 0; i < N; i++) begin
      logic sel;
      logic term_in;
      sel        = ctrl[i].pin_sel & ctrl[i].enable;
      term_in    = sel && (ctrl[i].mode == `DPH_MODE_TERM_IN)
                   && term_rise(trm_s2_q[i], trm_prev_q[i]);
      st_d[i]    = st_q[i];
      rack_d[i]  = 1'b0;
      tack_d[i]  = 1'b0;
      tout_d[i]  = 1'b0;
      toe_d[i]   = sel && (ctrl[i].mode == `DPH_MODE_TERM_OUT);
      peer_d[i]  = peer_q[i];
      cpulse_d[i] = 1'b0;
      if (!sel) begin
        st_d[i] = dph_pkg::DPH_IDLE;
      end else begin
        case (st_q[i])
          dph_pkg::DPH_IDLE: begin
            peer_d[i] = 1'b0;
            if (req_s2_q[i]) begin
              st_d[i]   = dph_pkg::DPH_SAMPLED;
              rack_d[i] = (ctrl[i].mode == `DPH_MODE_ACK);
            end
          end
          dph_pkg::DPH_SAMPLED, dph_pkg::DPH_XFER: begin
            if (term_in) begin
              st_d[i]     = dph_pkg::DPH_CLOSED;
              peer_d[i]   = 1'b1;
              cpulse_d[i] = 1'b1;
            end else if (ctrl[i].xfer_strobe) begin
              tack_d[i] = 1'b1;
              if (ctrl[i].last_xfer) begin
                st_d[i]     = dph_pkg::DPH_CLOSED;
                tout_d[i]   = (ctrl[i].mode == `DPH_MODE_TERM_OUT);
                cpulse_d[i] = 1'b1;
              end else begin
                st_d[i] = dph_pkg::DPH_XFER;
              end
            end
          end
          dph_pkg::DPH_CLOSED: begin
            // Stays inactive until core drops enable or pin_sel
            // A request still held by the peripheral cannot reopen it
            st_d[i] = dph_pkg::DPH_CLOSED;
          end
          default: st_d[i] = dph_pkg::DPH_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        st_q[i] <= dph_pkg::DPH_IDLE;
      end
      rack_q   <= '0;
      tack_q   <= '0;
      tout_q   <= '0;
      toe_q    <= '0;
      peer_q   <= '0;
      cpulse_q <= '0;
    end else begin
      st_q     <= st_d;
      rack_q   <= rack_d;
      tack_q   <= tack_d;
      tout_q   <= tout_d;
      toe_q    <= toe_d;
      peer_q   <= peer_d;
      cpulse_q <= cpulse_d;
    end
  end

  assign request_sampled_ack   = rack_q;
  assign transfer_ack          = tack_q;
  assign channel_terminate_out = tout_q;
  assign channel_terminate_oe  = toe_q;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      stat[i].req_pending    = req_s2_q[i];
      stat[i].active         = (st_q[i] == dph_pkg::DPH_SAMPLED) ||
                               (st_q[i] == dph_pkg::DPH_XFER);
      stat[i].closed_by_peer = peer_q[i];
      stat[i].closed_pulse   = cpulse_q[i];
    end
  end

  for (genvar g = 0; g < N; g++) begin : g_chk
    chk_req_sampled: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_q[g] == dph_pkg::DPH_IDLE && st_d[g] == dph_pkg::DPH_SAMPLED
       && ctrl[g].mode == `DPH_MODE_ACK) |=> request_sampled_ack[g])
      else $error("sampled ack missing");
    chk_sync_depth: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(req_s2_q[g]) |-> $past(ext_service_request[g], 2))
      else $error("request not two-stage synced");
    chk_xfer_ack: assert property (@(posedge mclk) disable iff (!rst_n)
      transfer_ack[g] |-> $past(ctrl[g].xfer_strobe) && $past(stat[g].active))
      else $error("transfer ack without transaction");
    chk_done_inactive: assert property (@(posedge mclk) disable iff (!rst_n)
      channel_terminate_out[g] |-> !stat[g].active ##1 !stat[g].active)
      else $error("channel active after terminate out");
    chk_peer_close: assert property (@(posedge mclk) disable iff (!rst_n)
      (stat[g].active && ctrl[g].pin_sel && ctrl[g].enable
       && ctrl[g].mode == `DPH_MODE_TERM_IN && trm_s2_q[g] && !trm_prev_q[g])
      |=> st_q[g] == dph_pkg::DPH_CLOSED && stat[g].closed_pulse)
      else $error("terminate input did not close");
    chk_pin_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      channel_terminate_oe[g] |-> $past(ctrl[g].mode) == `DPH_MODE_TERM_OUT)
      else $error("terminate driven in wrong mode");
    chk_pin_select: assert property (@(posedge mclk) disable iff (!rst_n)
      !$past(ctrl[g].pin_sel) |-> !request_sampled_ack[g] && !transfer_ack[g]
      && !channel_terminate_oe[g])
      else $error("handshake active on unselected pin");
    chk_req_accept: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_q[g] == dph_pkg::DPH_IDLE && req_s2_q[g] && ctrl[g].pin_sel
       && ctrl[g].enable) |=> st_q[g] == dph_pkg::DPH_SAMPLED)
      else $error("request not accepted");
    // Pulse widths, refusals and pin direction
    chk_ack_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
      request_sampled_ack[g] |=> !request_sampled_ack[g])
      else $error("sampled ack longer than one cycle");
    chk_ack_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      request_sampled_ack[g] |-> $past(ctrl[g].mode) == `DPH_MODE_ACK)
      else $error("sampled ack in terminate mode");
    chk_ack_refused: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_q[g] != dph_pkg::DPH_SAMPLED && st_q[g] != dph_pkg::DPH_XFER
       && ctrl[g].xfer_strobe) |=> !transfer_ack[g])
      else $error("transfer ack outside active channel");
    chk_term_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      channel_terminate_out[g] |-> channel_terminate_oe[g])
      else $error("terminate pulse without pin drive");
    chk_closed_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_q[g] == dph_pkg::DPH_CLOSED && ctrl[g].pin_sel && ctrl[g].enable)
      |=> st_q[g] == dph_pkg::DPH_CLOSED)
      else $error("closed channel reopened");
    chk_close_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
      stat[g].closed_pulse |-> st_q[g] == dph_pkg::DPH_CLOSED)
      else $error("close pulse without closed channel");
    chk_oe_follow: assert property (@(posedge mclk) disable iff (!rst_n)
      (ctrl[g].pin_sel && ctrl[g].enable && ctrl[g].mode == `DPH_MODE_TERM_OUT)
      |=> channel_terminate_oe[g])
      else $error("terminate pin not driven in output mode");
    chk_sel_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      !(ctrl[g].pin_sel && ctrl[g].enable) |=> st_q[g] == dph_pkg::DPH_IDLE)
      else $error("handshake state kept on unselected pin");
  end

endmodule : dph_handshake
`default_nettype wire

// ---- rtl/dph_cfg.svh ----
// Constants for the DMA peripheral handshake block.
// Assumes inclusion by bare name from rtl/.
`ifndef DPH_CFG_SVH
`define DPH_CFG_SVH

`define DPH_NUM_SETS       2
`define DPH_SYNC_STAGES    2
`define DPH_MODE_ACK       2'h0
`define DPH_MODE_TERM_OUT  2'h1
`define DPH_MODE_TERM_IN   2'h2
`define DPH_MODE_RST       2'h0

`endif

// ---- rtl/dph_pkg.sv ----
// Types for the DMA peripheral handshake block.
// Assumes dph_cfg.svh is compiled alongside.
package dph_pkg;

  typedef enum logic [1:0] {
    DPH_IDLE    = 2'b00,
    DPH_SAMPLED = 2'b01,
    DPH_XFER    = 2'b10,
    DPH_CLOSED  = 2'b11
  } dph_state_type;

  // Core-side command set for one channel
  typedef struct packed {
    logic       pin_sel;
    logic [1:0] mode;
    logic       enable;
    logic       xfer_strobe;
    logic       last_xfer;
  } dph_ctrl_type;

  // Core-side status for one channel
  typedef struct packed {
    logic       req_pending;
    logic       active;
    logic       closed_by_peer;
    logic       closed_pulse;
  } dph_stat_type;

endpackage : dph_pkg

// ---- dv/dph_periph_model.sv ----
// Peripheral model: raises service requests, may end its channel.
// Assumes one mclk domain; resolves the shared terminate pin from oe.
`timescale 1ns/1ps
`default_nettype none
`include "dph_cfg.svh"
module dph_periph_model (
  input  wire logic [`DPH_NUM_SETS-1:0] want_service,
  input  wire logic [`DPH_NUM_SETS-1:0] want_close,
  input  wire logic [`DPH_NUM_SETS-1:0] sampled_ack,
  input  wire logic [`DPH_NUM_SETS-1:0] term_out,
  input  wire logic [`DPH_NUM_SETS-1:0] term_oe,
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  output logic      [`DPH_NUM_SETS-1:0] service_request,
  output logic      [`DPH_NUM_SETS-1:0] terminate_pin
);
  logic [`DPH_NUM_SETS-1:0] close_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      service_request <= '0;
      close_q         <= '0;
    end else begin
      // Held until seen or closed, so a slow device never loses it
      service_request <= (service_request & ~(sampled_ack | terminate_pin)) | want_service;
      close_q         <= want_close;
    end
  end
  // Handshake block drive wins while its enable term_oe is high
  assign terminate_pin = (term_oe & term_out) | (~term_oe & close_q);
endmodule : dph_periph_model
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the handshake block with a peripheral model.
// Assumes the package and rtl/ headers are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dph_cfg.svh"
module tb;
  localparam int N = `DPH_NUM_SETS;
  logic mclk, rst_n;
  dph_pkg::dph_ctrl_type [N-1:0] ctrl;
  dph_pkg::dph_stat_type [N-1:0] stat;
  logic [N-1:0] req, rsa, xack, tin, tout, toe, want_s, want_c;
  int failures, checks, cycles, n;
  dph_handshake dph_handshake_i (.mclk(mclk), .rst_n(rst_n), .ctrl(ctrl), .stat(stat),
    .ext_service_request(req), .transfer_ack(xack), .request_sampled_ack(rsa),
    .channel_terminate_in(tin), .channel_terminate_out(tout), .channel_terminate_oe(toe));
  dph_periph_model dph_periph_model_i (.mclk(mclk), .rst_n(rst_n), .want_service(want_s),
    .want_close(want_c), .sampled_ack(rsa), .term_out(tout), .term_oe(toe),
    .service_request(req), .terminate_pin(tin));
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk
  task automatic setup(input int s, input logic sel, input logic [1:0] md);
    ctrl[s] = '0;
    @(negedge mclk);
    ctrl[s] = '{pin_sel: sel, mode: md, enable: 1'b1, default: 1'b0};
    repeat (2) @(negedge mclk);
    chk("oe", sel && md == `DPH_MODE_TERM_OUT, toe[s]);
    want_s[s] = 1'b1;
    @(negedge mclk);
    want_s[s] = 1'b0;
    for (n = 0; stat[s].active !== 1'b1 && n < 8; n++) @(negedge mclk);
  endtask : setup
  task automatic xfer(input int s, input logic last, input logic term);
    ctrl[s].xfer_strobe = 1'b1;
    ctrl[s].last_xfer = last;
    @(negedge mclk);
    ctrl[s].xfer_strobe = 1'b0;
    ctrl[s].last_xfer = 1'b0;
    if (xack[s] !== 1'b1) @(negedge mclk);
    chk("transfer ack", 1'b1, xack[s]);
    chk("terminate out", last & term, tout[s]);
    @(negedge mclk);
    chk("active", ~last, stat[s].active);
    chk("transfer ack end", 1'b0, xack[s]);
  endtask : xfer
  task automatic t_ack(input int s);
    setup(s, 1'b1, `DPH_MODE_ACK);
    chk("sample delay", 1'b1, n >= 2 && n <= 4);
    chk("sampled ack", 1'b1, rsa[s]);
    xfer(s, 1'b0, 1'b0);
    xfer(s, 1'b1, 1'b0);
    ctrl[s].xfer_strobe = 1'b1;
    @(negedge mclk);
    ctrl[s].xfer_strobe = 1'b0;
    chk("refused transfer ack", 1'b0, xack[s]);
    chk("closed stays", 1'b0, stat[s].active);
    $display("ack set %0d done", s);
  endtask : t_ack
  task automatic t_term_out(input int s);
    setup(s, 1'b1, `DPH_MODE_TERM_OUT);
    chk("no sampled ack", 1'b0, rsa[s]);
    xfer(s, 1'b1, 1'b1);
    $display("terminate out set %0d done", s);
  endtask : t_term_out
  task automatic t_term_in(input int s);
    setup(s, 1'b1, `DPH_MODE_TERM_IN);
    want_c[s] = 1'b1;
    for (n = 0; stat[s].closed_pulse !== 1'b1 && n < 8; n++) @(negedge mclk);
    chk("close delay", 1'b1, n <= 4);
    chk("closed by peer", 1'b1, stat[s].closed_by_peer);
    chk("active", 1'b0, stat[s].active);
    chk("closed pulse", 1'b1, stat[s].closed_pulse);
    want_c[s] = 1'b0;
    @(negedge mclk);
    chk("closed pulse end", 1'b0, stat[s].closed_pulse);
    $display("terminate in set %0d done", s);
  endtask : t_term_in
  task automatic t_unsel(input int s);
    setup(s, 1'b0, `DPH_MODE_TERM_OUT);
    chk("unselected", 1'b1, n == 8);
    chk("no ack", 1'b0, rsa[s]);
    chk("request pending", 1'b1, stat[s].req_pending);
    $display("unselected set %0d done", s);
  endtask : t_unsel
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    ctrl = '0;
    want_s = '0;
    want_c = '0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    for (int s = 0; s < N; s++) begin
      t_ack(s);
      t_term_out(s);
      t_term_in(s);
      t_unsel(s);
    end
    finish_test();
  end
endmodule : tb
`default_nettype wire
